// ### include/ofd_defines.vh
`ifndef OFD_DEFINES_VH
`define OFD_DEFINES_VH
// Integer operand length encodings.
`define OFD_LEN_BYTE 2'h0
`define OFD_LEN_WORD 2'h1
`define OFD_LEN_DWORD 2'h3
// Floating type bit encodings.
`define OFD_FLT_SINGLE 1'h1
`define OFD_FLT_DOUBLE 1'h0
// Condition code encodings.
`define OFD_CC_EQ 4'h0
`define OFD_CC_NE 4'h1
`define OFD_CC_CS 4'h2
`define OFD_CC_CC 4'h3
`define OFD_CC_HI 4'h4
`define OFD_CC_LS 4'h5
`define OFD_CC_GT 4'h6
`define OFD_CC_LE 4'h7
`define OFD_CC_FS 4'h8
`define OFD_CC_FC 4'h9
`define OFD_CC_LO 4'hA
`define OFD_CC_HS 4'hB
`define OFD_CC_LT 4'hC
`define OFD_CC_GE 4'hD
`define OFD_CC_TRUE 4'hE
`define OFD_CC_FALSE 4'hF
// Dedicated register selector encodings.
`define OFD_DR_USR 4'h0
`define OFD_DR_FP 4'h8
`define OFD_DR_SP 4'h9
`define OFD_DR_SB 4'hA
`define OFD_DR_PSR 4'hD
`define OFD_DR_ITB 4'hE
`define OFD_DR_MODR 4'hF
// One-hot register select bit positions.
`define OFD_SEL_USR 0
`define OFD_SEL_FP 1
`define OFD_SEL_SP 2
`define OFD_SEL_SB 3
`define OFD_SEL_PSR 4
`define OFD_SEL_ITB 5
`define OFD_SEL_MODR 6
`define OFD_SEL_W 7
// Format 2 operation codes.
`define OFD_F2_QADD 3'h0
`define OFD_F2_QCMP 3'h1
`define OFD_F2_SPR 3'h2
`define OFD_F2_SCOND 3'h3
`define OFD_F2_ACB 3'h4
`define OFD_F2_QMOV 3'h5
`define OFD_F2_LPR 3'h6
// Format 2 identifying low bits.
`define OFD_F2_TAG 2'h3
// String match field encodings.
`define OFD_MATCH_NONE 2'h0
`define OFD_MATCH_WHILE 2'h1
`define OFD_MATCH_UNTIL 2'h3
// Strobe synchroniser depth.
`define OFD_SYNC_W 3
`endif

// ### logic/ofd_cond_eval.v
`timescale 1ns/1ps
`include "ofd_defines.vh"

// Evaluates a four-bit condition code against the processor flags.
module ofd_cond_eval (
  input wire [3:0] cond, // Condition code.
  input wire flag_z, // Equal flag.
  input wire flag_c, // Borrow-out flag.
  input wire flag_l, // Unsigned-above bit.
  input wire flag_n, // Signed-greater bit.
  input wire flag_f, // User marker bit.
  output reg cond_true // Condition holds.
);

  // Pure table lookup; shared by branch and set-on-condition paths.
  always @* begin
    case (cond)
      `OFD_CC_EQ: cond_true = flag_z; // RL3
      `OFD_CC_NE: cond_true = ~flag_z; // RL3
      `OFD_CC_CS: cond_true = flag_c; // RL3
      `OFD_CC_CC: cond_true = ~flag_c; // RL3
      `OFD_CC_HI: cond_true = flag_l; // RL4
      `OFD_CC_LS: cond_true = ~flag_l; // RL4
      `OFD_CC_GT: cond_true = flag_n; // RL7
      `OFD_CC_LE: cond_true = ~flag_n; // RL7
      `OFD_CC_FS: cond_true = flag_f; // RL8
      `OFD_CC_FC: cond_true = ~flag_f; // RL8
      `OFD_CC_LO: cond_true = ~flag_l & ~flag_z; // RL5
      `OFD_CC_HS: cond_true = flag_l | flag_z; // RL6
      `OFD_CC_LT: cond_true = ~flag_n & ~flag_z; // RL7
      `OFD_CC_GE: cond_true = flag_n | flag_z; // RL7
      `OFD_CC_TRUE: cond_true = 1'b1; // RL9
      default: cond_true = 1'b0; // RL9
    endcase
  end

endmodule

// ### logic/ofd_decoder.v
`timescale 1ns/1ps
`include "ofd_defines.vh"

// What this block does
// RL1: Length field 00 byte, 01 word, 11 double.
// RL2: Float bit 1 single, 0 double precision.
// RL3: Codes 0-3 test equal and borrow flags.
// RL4: Codes 4 and 5 test unsigned-above bit.
// RL5: Code 1010 needs above and equal clear.
// RL6: Code 1011 needs above or equal set.
// RL7: Codes 6,7,12,13 test signed-greater and equal.
// RL8: Codes 8 and 9 test user marker.
// RL9: Code 1110 always true, 1111 always false.
// RL10: Short field sign-extended for quick instructions.
// RL11: Set-on-condition reads short field as condition.
// RL12: Selector maps seven dedicated registers.
// RL13: Other selector codes are reserved, unmapped.
// RL14: String options: translate, backward, match mode.
// RL15: Each general field gives an addressing mode.
// RL16: Register field gives general register number.
// RL17: External master drops strobe before T4.
// RL18: Reserved selector flags undefined, writes nothing.
module ofd_decoder #(
  parameter DATA_W = 32 // Width of the sign-extended quick value.
) (
  input wire clock, // Processor clock.
  input wire reset, // Synchronous reset, active high.
  input wire instr_valid, // Instruction word present this cycle.
  input wire [23:0] instr_word, // Instruction bytes, first byte low.
  input wire flag_z, // Equal flag.
  input wire flag_c, // Borrow-out flag.
  input wire flag_l, // Unsigned-above bit.
  input wire flag_n, // Signed-greater bit.
  input wire flag_f, // User marker bit.
  input wire [3:0] branch_cond, // Condition field of a conditional branch.
  input wire [2:0] string_opts, // String options: match high pair, backward, translate.
  input wire address_strobe_in_n, // Strobe from an external bus master, active low.
  output reg dec_valid_q, // Decoded results valid.
  output reg [1:0] op_len_q, // Integer length code.
  output reg [2:0] op_bytes_q, // Integer length in bytes.
  output reg float_single_q, // Single precision selected.
  output reg is_format2_q, // Word is a short-field instruction.
  output reg [2:0] f2_op_q, // Short-field operation code.
  output reg [DATA_W-1:0] quick_value_q, // Sign-extended quick value.
  output reg quick_use_q, // Quick value used by this instruction.
  output reg scond_q, // Set-on-condition result.
  output reg branch_taken_q, // Branch condition result.
  output reg [`OFD_SEL_W-1:0] dreg_sel_q, // One-hot dedicated register select.
  output reg dreg_write_q, // Load to a dedicated register.
  output reg undefined_q, // Undefined instruction detected.
  output reg [4:0] gen1_mode_q, // First general operand mode.
  output reg [4:0] gen2_mode_q, // Second general operand mode.
  output reg [2:0] gen1_reg_q, // Register number of first operand.
  output reg [2:0] gen2_reg_q, // Register number of second operand.
  output reg str_translate_q, // String translation enabled.
  output reg str_backward_q, // String steps backward.
  output reg [1:0] str_match_q, // String match mode.
  output reg str_match_bad_q, // String match code 10 seen.
  output reg ext_cycle_q // External master cycle in progress.
);

  // Field slices of a short-field (format 2) instruction.
  wire [1:0] f2_tag = instr_word[3:2];
  wire [1:0] len_f = instr_word[1:0];
  wire [3:0] short_f = instr_word[10:7];
  wire [2:0] op_f = instr_word[6:4];
  wire [4:0] gen_f = instr_word[15:11];

  wire cond_short; // Set-on-condition evaluation.
  wire cond_branch; // Branch evaluation.
  reg [`OFD_SYNC_W-1:0] strobe_sync_q; // Strobe synchroniser.
  reg [`OFD_SYNC_W-1:0] strobe_sync_d;
  reg strobe_stable_q; // Agreed strobe level, active high.
  reg strobe_stable_d;

  // Decodes the dedicated register selector; reserved codes give zero.
  function [`OFD_SEL_W-1:0] dreg_decode;
    input [3:0] code;
    begin
      dreg_decode = {`OFD_SEL_W{1'b0}};
      case (code)
        `OFD_DR_USR: dreg_decode[`OFD_SEL_USR] = 1'b1; // RL12
        `OFD_DR_FP: dreg_decode[`OFD_SEL_FP] = 1'b1;
        `OFD_DR_SP: dreg_decode[`OFD_SEL_SP] = 1'b1;
        `OFD_DR_SB: dreg_decode[`OFD_SEL_SB] = 1'b1;
        `OFD_DR_PSR: dreg_decode[`OFD_SEL_PSR] = 1'b1;
        `OFD_DR_ITB: dreg_decode[`OFD_SEL_ITB] = 1'b1;
        `OFD_DR_MODR: dreg_decode[`OFD_SEL_MODR] = 1'b1;
        default: dreg_decode = {`OFD_SEL_W{1'b0}}; // RL13
      endcase
    end
  endfunction

  // Byte count of an integer length code; the unused code 10 gives zero.
  function [2:0] len_bytes;
    input [1:0] code;
    begin
      case (code)
        `OFD_LEN_BYTE: len_bytes = 3'h1; // RL1
        `OFD_LEN_WORD: len_bytes = 3'h2; // RL1
        `OFD_LEN_DWORD: len_bytes = 3'h4; // RL1
        default: len_bytes = 3'h0;
      endcase
    end
  endfunction

  // Short field is reused as a condition code for set-on-condition.
  ofd_cond_eval u_cond_short (
    .cond(short_f), // RL11
    .flag_z(flag_z),
    .flag_c(flag_c),
    .flag_l(flag_l),
    .flag_n(flag_n),
    .flag_f(flag_f),
    .cond_true(cond_short)
  );

  // Same table for the conditional branch.
  ofd_cond_eval u_cond_branch (
    .cond(branch_cond),
    .flag_z(flag_z),
    .flag_c(flag_c),
    .flag_l(flag_l),
    .flag_n(flag_n),
    .flag_f(flag_f),
    .cond_true(cond_branch)
  );

  // The strobe is asynchronous; a level counts once stages two and three agree.
  always @* begin
    strobe_sync_d = {strobe_sync_q[`OFD_SYNC_W-2:0], ~address_strobe_in_n};
    strobe_stable_d = strobe_stable_q;
    if (strobe_sync_q[1] == strobe_sync_q[2]) begin
      strobe_stable_d = strobe_sync_q[2];
    end
  end

  // Strobe tracking; the master releases it before T4, so a high level here
  // simply marks an external cycle and needs no timeout.
  always @(posedge clock) begin
    if (reset) begin
      strobe_sync_q <= {`OFD_SYNC_W{1'b0}};
      strobe_stable_q <= 1'b0;
      ext_cycle_q <= 1'b0;
    end else begin
      strobe_sync_q <= strobe_sync_d;
      strobe_stable_q <= strobe_stable_d;
      ext_cycle_q <= strobe_stable_d; // RL17
    end
  end

  // Registered decode; results other than dec_valid_q update only with a valid instruction.
  always @(posedge clock) begin
    if (reset) begin
      dec_valid_q <= 1'b0;
      op_len_q <= `OFD_LEN_BYTE;
      op_bytes_q <= 3'h0;
      float_single_q <= 1'b0;
      is_format2_q <= 1'b0;
      f2_op_q <= 3'h0;
      quick_value_q <= {DATA_W{1'b0}};
      quick_use_q <= 1'b0;
      scond_q <= 1'b0;
      branch_taken_q <= 1'b0;
      dreg_sel_q <= {`OFD_SEL_W{1'b0}};
      dreg_write_q <= 1'b0;
      undefined_q <= 1'b0;
      gen1_mode_q <= 5'h00;
      gen2_mode_q <= 5'h00;
      gen1_reg_q <= 3'h0;
      gen2_reg_q <= 3'h0;
      str_translate_q <= 1'b0;
      str_backward_q <= 1'b0;
      str_match_q <= `OFD_MATCH_NONE;
      str_match_bad_q <= 1'b0;
    end else begin
      dec_valid_q <= instr_valid;
      if (instr_valid) begin
        // Length and precision come straight from the low bits.
        op_len_q <= len_f; // RL1
        op_bytes_q <= len_bytes(len_f); // RL1
        float_single_q <= (instr_word[0] == `OFD_FLT_SINGLE); // RL2
        is_format2_q <= (f2_tag == `OFD_F2_TAG);
        f2_op_q <= op_f;
        // Sign extension happens for every word; quick_use says when it counts.
        quick_value_q <= {{(DATA_W-4){short_f[3]}}, short_f}; // RL10
        quick_use_q <= (instr_word[3:2] == `OFD_F2_TAG) &&
          ((op_f == `OFD_F2_QMOV) || (op_f == `OFD_F2_QADD) ||
           (op_f == `OFD_F2_QCMP) || (op_f == `OFD_F2_ACB)); // RL10
        scond_q <= cond_short; // RL11
        branch_taken_q <= cond_branch;
        // Dedicated register paths: reserved codes select nothing.
        if ((instr_word[3:2] == `OFD_F2_TAG) &&
            ((op_f == `OFD_F2_LPR) || (op_f == `OFD_F2_SPR))) begin
          dreg_sel_q <= dreg_decode(short_f); // RL12
          // A reserved selector is undefined and blocks the write.
          if (dreg_decode(short_f) == {`OFD_SEL_W{1'b0}}) begin
            undefined_q <= 1'b1; // RL18
            dreg_write_q <= 1'b0; // RL18
          end else begin
            undefined_q <= 1'b0;
            dreg_write_q <= (op_f == `OFD_F2_LPR);
          end
        end else begin
          dreg_sel_q <= {`OFD_SEL_W{1'b0}};
          dreg_write_q <= 1'b0;
          undefined_q <= 1'b0;
        end
        // Two general fields, each a mode selector with a register number.
        gen1_mode_q <= instr_word[15:11]; // RL15
        gen2_mode_q <= instr_word[10:6]; // RL15
        gen1_reg_q <= gen_f[2:0]; // RL16
        gen2_reg_q <= instr_word[8:6]; // RL16
        // String options are taken from their own port; the match mode also uses word bit 16.
        str_translate_q <= string_opts[0]; // RL14
        str_backward_q <= string_opts[1]; // RL14
        str_match_q <= {string_opts[2], string_opts[2] | instr_word[16]}; // RL14
        str_match_bad_q <= string_opts[2] & ~instr_word[16];
      end
    end
  end

endmodule

// ### verif/ofd_decoder_asserts.sv
`timescale 1ns/1ps
`include "ofd_defines.vh"
// Port checks: decode outputs are tied to the word taken one edge earlier; ext_cycle_q is only covered.
module ofd_decoder_asserts #(parameter DATA_W = 32) (
  input wire clock, // Clock.
  input wire reset, // Reset.
  input wire instr_valid, // Word strobe.
  input wire [23:0] instr_word, // Word.
  input wire flag_z, // Equal flag.
  input wire flag_l, // Above bit.
  input wire [3:0] branch_cond, // Branch code.
  input wire [2:0] string_opts, // Options.
  input wire [1:0] op_len_q, // Length code.
  input wire [2:0] op_bytes_q, // Length bytes.
  input wire float_single_q, // Single.
  input wire [DATA_W-1:0] quick_value_q, // Quick value.
  input wire branch_taken_q, // Branch result.
  input wire [`OFD_SEL_W-1:0] dreg_sel_q, // Register select.
  input wire dreg_write_q, // Register load.
  input wire undefined_q, // Undefined.
  input wire [4:0] gen1_mode_q, // Mode one.
  input wire [4:0] gen2_mode_q, // Mode two.
  input wire [2:0] gen1_reg_q, // Register one.
  input wire [2:0] gen2_reg_q, // Register two.
  input wire str_translate_q, // Translate.
  input wire str_backward_q, // Backward.
  input wire ext_cycle_q // Foreign cycle.
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // A load or store with one of the nine unmapped selector codes.
  wire rsv = instr_word[3:2] == 2'h3 && (instr_word[6:4] == 3'h2 || instr_word[6:4] == 3'h6)
    && ((instr_word[10:7] != 4'h0 && instr_word[10:7] < 4'h8) || instr_word[10:7] == 4'hB || instr_word[10:7] == 4'hC);
  len_bytes_a: assert property (instr_valid && instr_word[1:0] != 2'h2 |=> op_len_q == $past(instr_word[1:0])
    && op_bytes_q == (op_len_q == 2'h0 ? 3'h1 : (op_len_q == 2'h1 ? 3'h2 : 3'h4))) else $error("length decode wrong");
  float_bit_a: assert property (instr_valid |=> float_single_q == $past(instr_word[0]))
    else $error("float type wrong");
  quick_sext_a: assert property (instr_valid |=> quick_value_q == DATA_W'($signed($past(instr_word[10:7]))))
    else $error("quick value not sign extended");
  equal_cond_a: assert property (instr_valid && branch_cond == 4'h0 |=> branch_taken_q == $past(flag_z))
    else $error("equal condition wrong");
  lower_cond_a: assert property (instr_valid && branch_cond == 4'hA |=> branch_taken_q == !$past(flag_l || flag_z))
    else $error("lower condition wrong");
  fixed_cond_a: assert property (instr_valid && branch_cond[3:1] == 3'h7 |=> branch_taken_q == !$past(branch_cond[0]))
    else $error("fixed condition wrong");
  reserved_sel_a: assert property (instr_valid && rsv |=> undefined_q && !dreg_write_q && dreg_sel_q == 7'h00)
    else $error("reserved selector not refused");
  gen_fields_a: assert property (instr_valid |=> gen1_mode_q == $past(instr_word[15:11])
    && gen2_mode_q == $past(instr_word[10:6]) && gen1_reg_q == gen1_mode_q[2:0] && gen2_reg_q == gen2_mode_q[2:0])
    else $error("operand fields wrong");
  string_opts_a: assert property (instr_valid |=> {str_backward_q, str_translate_q} == $past(string_opts[1:0]))
    else $error("string options wrong");
  hold_outputs_a: assert property (!instr_valid |=> $stable(gen1_mode_q) && $stable(op_len_q))
    else $error("outputs moved without a word");
  undef_c: cover property (instr_valid && rsv ##1 undefined_q);
  load_c: cover property (dreg_write_q);
  taken_c: cover property (branch_taken_q);
  ext_c: cover property (ext_cycle_q);
endmodule
bind ofd_decoder ofd_decoder_asserts #(.DATA_W(DATA_W)) i_chk (.clock, .reset, .instr_valid, .instr_word, .flag_z,
  .flag_l, .branch_cond, .string_opts, .op_len_q, .op_bytes_q, .float_single_q, .quick_value_q, .branch_taken_q,
  .dreg_sel_q, .dreg_write_q, .undefined_q, .gen1_mode_q, .gen2_mode_q, .gen1_reg_q, .gen2_reg_q, .str_translate_q,
  .str_backward_q, .ext_cycle_q);

// ### verif/ofd_fetch_model.sv
`timescale 1ns/1ps
// Fetch queue stand-in: one word per taken edge, and a foreign bus master strobe.
module ofd_fetch_model (
  input wire clock, // Clock.
  output logic instr_valid = 1'b0, // Word present.
  output logic [23:0] instr_word = 24'h00_0000, // Word.
  output logic address_strobe_in_n = 1'b1 // Foreign strobe, pulled high.
);
  logic [23:0] last = 24'h00_0000; // Last pattern on the word lines.
  // Idle cycles flip the lines every cycle so a stale word can never look right.
  task automatic send(input logic [23:0] w, input int gap);
    repeat (gap) begin
      @(posedge clock);
      instr_valid <= 1'b0;
      instr_word <= ~last;
      last = ~last;
    end
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word <= w;
    last = w;
  endtask
  // Drop the valid line after the last word without presenting another one.
  task automatic idle();
    @(posedge clock);
    instr_valid <= 1'b0;
  endtask
  // Strobe low for two cycles, released before the fourth state.
  task automatic ext_cycle();
    @(posedge clock);
    address_strobe_in_n <= 1'b0;
    repeat (2) @(posedge clock);
    address_strobe_in_n <= 1'b1;
  endtask
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
// The driver notes each expected decode; the monitor checks it when a result appears.
module tb;
  logic clock = 1'b0; // Clock.
  logic reset = 1'b1; // Reset.
  logic [4:0] flg = 5'h00; // Flags: equal, borrow, above, greater, marker.
  logic [3:0] bc = 4'h0; // Branch code.
  logic [2:0] opts = 3'h0; // String options.
  logic [1:0] lens [3] = '{2'h0, 2'h1, 2'h3}; // Legal length codes.
  logic [75:0] expq [$]; // Expected results, oldest first.
  logic seen_ext = 1'b0; // Set once the foreign cycle flag was seen high.
  int failures = 0;
  int n_checks = 0;
  wire instr_valid, address_strobe_in_n, dec_valid_q, float_single_q, is_format2_q, quick_use_q, scond_q;
  wire branch_taken_q, dreg_write_q, undefined_q, str_translate_q, str_backward_q, str_match_bad_q, ext_cycle_q;
  wire [23:0] instr_word;
  wire [1:0] op_len_q, str_match_q;
  wire [2:0] op_bytes_q, f2_op_q, gen1_reg_q, gen2_reg_q;
  wire [4:0] gen1_mode_q, gen2_mode_q;
  wire [31:0] quick_value_q;
  wire [6:0] dreg_sel_q;
  ofd_fetch_model i_fq (.clock, .instr_valid, .instr_word, .address_strobe_in_n);
  ofd_decoder i_dut (.clock, .reset, .instr_valid, .instr_word, .flag_z(flg[4]), .flag_c(flg[3]), .flag_l(flg[2]),
    .flag_n(flg[1]), .flag_f(flg[0]), .branch_cond(bc), .string_opts(opts), .address_strobe_in_n, .dec_valid_q,
    .op_len_q, .op_bytes_q, .float_single_q, .is_format2_q, .f2_op_q, .quick_value_q, .quick_use_q, .scond_q,
    .branch_taken_q, .dreg_sel_q, .dreg_write_q, .undefined_q, .gen1_mode_q, .gen2_mode_q, .gen1_reg_q, .gen2_reg_q,
    .str_translate_q, .str_backward_q, .str_match_q, .str_match_bad_q, .ext_cycle_q);
  always #20 clock = ~clock;
  // Condition table, codes 15 down to 0.
  function automatic logic cc(input logic [3:0] c, input logic [4:0] f);
    logic [15:0] t;
    t = {1'b0, 1'b1, f[1] | f[4], ~f[1] & ~f[4], f[2] | f[4], ~f[2] & ~f[4], ~f[0], f[0], ~f[1], f[1], ~f[2], f[2],
      ~f[3], f[3], ~f[4], f[4]};
    return t[c];
  endfunction
  // Expected outputs; the top bit is the short-field flag, the fourth from the top says whether the register select applies.
  function automatic logic [75:0] expv(input logic [23:0] w, input logic [4:0] f, input logic [3:0] c,
    input logic [2:0] o);
    logic [6:0] sel;
    logic chk;
    chk = w[6:4] == 3'h2 || w[6:4] == 3'h6;
    case (w[10:7])
      4'h0: sel = 7'h01;
      4'h8: sel = 7'h02;
      4'h9: sel = 7'h04;
      4'hA: sel = 7'h08;
      4'hD: sel = 7'h10;
      4'hE: sel = 7'h20;
      4'hF: sel = 7'h40;
      default: sel = 7'h00;
    endcase
    return {1'b1, w[6:4] == 3'h0 || w[6:4] == 3'h1 || w[6:4] == 3'h4 || w[6:4] == 3'h5, o[2] & ~w[16],
      chk, w[1:0], (w[1:0] == 2'h0) ? 3'h1 : (w[1] ? 3'h4 : 3'h2), w[0], w[6:4], 32'($signed(w[10:7])),
      cc(w[10:7], f), cc(c, f), chk && sel == 7'h00, w[6:4] == 3'h6 && sel != 7'h00, w[15:11], w[10:6], w[13:11],
      w[8:6], o[0], o[1], o[2], o[2] | w[16], chk ? sel : 7'h00};
  endfunction
  function automatic logic [23:0] mk(input logic [3:0] s, input logic [2:0] op, input logic [1:0] i);
    return {8'($urandom), 5'($urandom), s, op, 2'h3, i};
  endfunction
  task automatic bad(input string m);
    $display("BAD %0t %s", $time, m);
    failures++;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Note the expectation, then present word and operand state at the same edge.
  task automatic go(input logic [23:0] w, input logic [4:0] f, input logic [3:0] c, input logic [2:0] o, input int g);
    expq.push_back(expv(w, f, c, o));
    i_fq.send(w, g);
    flg <= f;
    bc <= c;
    opts <= o;
  endtask
  // Results stand one edge after the word; compare against the oldest note.
  always @(posedge clock) begin
    logic [75:0] e;
    logic [75:0] o;
    if (ext_cycle_q === 1'b1) seen_ext <= 1'b1;
    if (dec_valid_q === 1'b1) begin
      if (expq.size() == 0) begin
        bad("result without a word");
      end else begin
        e = expq.pop_front();
        o = {is_format2_q, quick_use_q, str_match_bad_q, e[72], op_len_q, op_bytes_q, float_single_q, f2_op_q,
          quick_value_q, scond_q, branch_taken_q, undefined_q, dreg_write_q, gen1_mode_q, gen2_mode_q, gen1_reg_q,
          gen2_reg_q, str_translate_q, str_backward_q, str_match_q, dreg_sel_q};
        n_checks++;
        if (o !== e) bad("decode mismatch");
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clock);
    bad("timeout");
    end_sim();
  end
  initial begin
    int s;
    int f;
    s = $urandom(71);
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    // Every code against every flag combination, back to back.
    for (s = 0; s < 16; s++)
      for (f = 0; f < 32; f++) go(mk(4'(s), 3'h3, 2'h0), 5'(f), 4'(s), 3'($urandom), 0);
    $display("condition test done");
    // Every selector for store then load, with a gap.
    for (s = 0; s < 32; s++) go(mk(4'(s), s < 16 ? 3'h2 : 3'h6, 2'h1), 5'($urandom), 4'($urandom), 3'($urandom), 1);
    $display("selector test done");
    for (s = 0; s < 300; s++) go(mk(4'($urandom), 3'($urandom_range(6)), lens[$urandom_range(2)]), 5'($urandom),
      4'($urandom), 3'($urandom), $urandom_range(2));
    $display("random test done");
    i_fq.idle();
    i_fq.ext_cycle();
    repeat (8) @(posedge clock);
    n_checks++;
    if (expq.size() != 0) bad("results missing");
    n_checks++;
    if (seen_ext !== 1'b1) bad("foreign cycle not flagged");
    $display("strobe test done");
    end_sim();
  end
endmodule
